/* File: inc/adcseq_pkg.sv */
// ----------------------------------------------------------------
// shared constants and types of the conversion sequencer
// ----------------------------------------------------------------
package adcseq_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL0 = 8'h00;  // conv_control_reg0
    localparam logic [7:0] OFS_CTRL1 = 8'h04;  // conv_control_reg1
    localparam logic [7:0] OFS_STATUS = 8'h08; // sticky event flags, write one to clear
    localparam logic [7:0] OFS_MASK = 8'h0c;   // conv_interrupt_enable, same layout
    localparam logic [7:0] OFS_RES_LO = 8'h10; // result_low_byte
    localparam logic [7:0] OFS_RES_HI = 8'h14; // result_high_byte

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL0_START = 0; // start control bit
    localparam int CTRL0_POWER = 1; // conv_power_enable
    localparam int CTRL0_BUSY = 2;  // conv_busy_flag, read only
    localparam int CTRL0_GIE = 3;   // global_interrupt_enable
    localparam int STAT_DONE = 0;   // conversion complete event
    localparam int DIV_W = 3;       // conv_clock_div_select width

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [DIV_W-1:0] RST_DIV_SEL = 3'h0; // divide by one
    localparam logic RST_FLAG = 1'h0;                // all flags clear
    localparam int RES_W = 12;                       // result width
    localparam logic [3:0] SAMPLE_PERIODS = 4'h4;    // sample_phase_time
    localparam logic [3:0] CONVERT_PERIODS = 4'hc;   // conversion phase
    localparam logic [4:0] TOTAL_PERIODS = 5'h10;    // total_conversion_time

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic gie;   // global_interrupt_enable
        logic busy;  // conv_busy_flag
        logic power; // conv_power_enable
        logic start; // start control bit
    } adcseq_ctrl_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } adcseq_state_t;

endpackage

/* File: verilog/adcseq_clkdiv.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------
// power-of-two divider: one tick per converter clock period
// ----------------------------------------------------------------
module adcseq_clkdiv #(
    parameter int DIV_W = adcseq_pkg::DIV_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic [DIV_W-1:0] sel,
    output logic tick
);
    localparam int CNT_W = (1 << DIV_W) - 1; // widest count, code all ones

    generate
        if (DIV_W < 1 || DIV_W > 4)
        begin : g_chk
            $error("adcseq_clkdiv: DIV_W out of range");
        end
    endgenerate

    logic [CNT_W-1:0] cnt_ff; // cycles into current period
    logic tick_ff; // period end pulse
    wire [CNT_W-1:0] limit = CNT_W'((1 << sel) - 1); // last count of period
    wire wrap = (cnt_ff >= limit); // >= keeps a shrinking select safe

    // divide by 1, 2, 4 ... by select code
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= (clr || wrap) ? '0 : cnt_ff + 1'b1;
            tick_ff <= wrap && !clr;
        end
    end

    assign tick = tick_ff;

    // gap checker helper: cycles since last tick, select stability
    logic [8:0] gap_h;
    logic seen_h;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gap_h <= '0;
            seen_h <= 1'b0;
        end
        else
        begin
            gap_h <= (tick_ff || clr) ? 9'h001 : gap_h + 9'h001;
            seen_h <= (tick_ff && !clr && $stable(sel)) ? 1'b1 :
                      ((clr || !$stable(sel)) ? 1'b0 : seen_h);
        end
    end

    a_div_spacing: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_ff && seen_h && $stable(sel)) |-> (gap_h == 9'(1 << sel)))
        else $error("converter clock tick spacing wrong");

endmodule // adcseq_clkdiv

/* File: verilog/adcseq_top.sv */
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/10ps
// Summary of operation
// - start pulse low-high-low begins one conversion when power enable is set
// - busy flag set once conversion starts
// - busy flag clears itself on completion
// - completion sets flag; enabled flag raises interrupt
// - converter clock is system clock divided 2^select
// - analog power follows power enable bit
// - sampling lasts four converter clock periods
// - conversion twelve more; sixteen in total
// - conversion runs in hardware, software continues
// - result is twelve bits wide
// - completed result readable after busy falls
module adcseq_top #(
    parameter int RES_W = adcseq_pkg::RES_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic conv_power_on,
    output logic conv_sample,
    output logic conv_reset,
    output logic [RES_W-1:0] sar_code,
    input wire logic comp_in
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    generate
        if (RES_W < 9 || RES_W > 16)
        begin : g_chk
            $error("adcseq_top: RES_W must be 9 to 16");
        end
    endgenerate

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    adcseq_pkg::adcseq_ctrl_t ctrl_ff; // control bits
    adcseq_pkg::adcseq_ctrl_t nxt_ctrl;
    adcseq_pkg::adcseq_state_t state_ff; // sequencer state
    adcseq_pkg::adcseq_state_t nxt_state;
    logic [adcseq_pkg::DIV_W-1:0] div_sel_ff; // conv_clock_div_select
    logic status_ff; // sticky completion flag
    logic mask_ff; // conv_interrupt_enable
    logic [3:0] phase_cnt_ff; // ticks within phase
    logic [RES_W-1:0] code_ff; // successive approximation code
    logic [RES_W-1:0] bit_ff; // bit under trial
    logic [RES_W-1:0] result_ff; // last completed result
    logic [31:0] prdata_ff; // read data
    logic pready_ff; // access answered
    logic pslverr_ff; // unmapped access
    logic irq_ff; // interrupt level
    logic power_on_ff; // analog power
    logic sample_ff; // sampling switch
    logic reset_ff; // converter reset
    logic comp_s1_ff; // comparator sync stage one
    logic comp_s2_ff; // comparator sync stage two
    logic tick; // converter clock period end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc = psel && penable && !pready_ff; // first access cycle
    wire fin = psel && penable && pready_ff; // completing edge
    wire hit_ctrl0 = (paddr == adcseq_pkg::OFS_CTRL0);
    wire hit_ctrl1 = (paddr == adcseq_pkg::OFS_CTRL1);
    wire hit_stat = (paddr == adcseq_pkg::OFS_STATUS);
    wire hit_mask = (paddr == adcseq_pkg::OFS_MASK);
    wire hit_rlo = (paddr == adcseq_pkg::OFS_RES_LO);
    wire hit_rhi = (paddr == adcseq_pkg::OFS_RES_HI);
    wire hit_any = hit_ctrl0 || hit_ctrl1 || hit_stat || hit_mask || hit_rlo || hit_rhi;
    wire wr = fin && pwrite && !pslverr_ff; // write takes effect
    wire wr_ctrl0 = wr && hit_ctrl0;
    wire wr_ctrl1 = wr && hit_ctrl1;
    wire wr_stat = wr && hit_stat;
    wire wr_mask = wr && hit_mask;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [31:0] rd_ctrl0 = {28'h0, ctrl_ff}; // busy polled here
    wire [31:0] rd_ctrl1 = {29'h0, div_sel_ff};
    wire [31:0] rd_stat = {31'h0, status_ff};
    wire [31:0] rd_mask = {31'h0, mask_ff};
    wire [31:0] rd_rlo = {24'h0, result_ff[7:0]};
    wire [31:0] rd_rhi = {24'h0, 8'(result_ff[RES_W-1:8])};
    wire [31:0] rd_data = hit_ctrl0 ? rd_ctrl0 :
                          hit_ctrl1 ? rd_ctrl1 :
                          hit_stat ? rd_stat :
                          hit_mask ? rd_mask :
                          hit_rlo ? rd_rlo :
                          hit_rhi ? rd_rhi : 32'h0;

    // ------------------------------------------------------------
    // start, power and sequence events
    // ------------------------------------------------------------
    wire new_start = wr_ctrl0 ? pwdata[adcseq_pkg::CTRL0_START] : ctrl_ff.start;
    wire new_power = wr_ctrl0 ? pwdata[adcseq_pkg::CTRL0_POWER] : ctrl_ff.power;
    wire new_gie = wr_ctrl0 ? pwdata[adcseq_pkg::CTRL0_GIE] : ctrl_ff.gie;
    wire start_fall = ctrl_ff.start && !new_start; // end of low-high-low pulse
    wire go = start_fall && new_power;
    wire running = (state_ff != adcseq_pkg::ST_IDLE);
    wire abort = running && (new_start || !new_power);
    wire last_sample = (phase_cnt_ff == adcseq_pkg::SAMPLE_PERIODS - 4'h1);
    wire last_conv = (phase_cnt_ff == adcseq_pkg::CONVERT_PERIODS - 4'h1);
    wire done_ev = (state_ff == adcseq_pkg::ST_CONVERT) && tick && last_conv && !abort;
    wire keep_bit = comp_s2_ff; // input at or above trial code
    wire [RES_W-1:0] sar_next = (keep_bit ? code_ff : (code_ff & ~bit_ff)) | (bit_ff >> 1);
    wire [RES_W-1:0] msb = {1'b1, {(RES_W-1){1'b0}}};
    wire nxt_status = (status_ff && !(wr_stat && pwdata[adcseq_pkg::STAT_DONE])) || done_ev;
    wire nxt_mask = wr_mask ? pwdata[adcseq_pkg::STAT_DONE] : mask_ff;

    // ------------------------------------------------------------
    // converter clock divider
    // ------------------------------------------------------------
    adcseq_clkdiv #(
        .DIV_W(adcseq_pkg::DIV_W)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .clr(go),
        .sel(div_sel_ff),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // next state of the sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            adcseq_pkg::ST_IDLE:
            begin
                if (go)
                    nxt_state = adcseq_pkg::ST_SAMPLE;
            end
            adcseq_pkg::ST_SAMPLE:
            begin
                if (tick && last_sample)
                    nxt_state = adcseq_pkg::ST_CONVERT;
            end
            adcseq_pkg::ST_CONVERT:
            begin
                if (tick && last_conv)
                    nxt_state = adcseq_pkg::ST_IDLE;
            end
            default:
            begin
                nxt_state = adcseq_pkg::ST_IDLE; // illegal code recovers
            end
        endcase
        if (abort)
            nxt_state = adcseq_pkg::ST_IDLE;
    end

    // next control word, busy follows the sequencer
    always_comb
    begin
        nxt_ctrl.start = new_start;
        nxt_ctrl.power = new_power;
        nxt_ctrl.gie = new_gie;
        nxt_ctrl.busy = (nxt_state != adcseq_pkg::ST_IDLE);
    end

    // ------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            comp_s1_ff <= 1'b0;
            comp_s2_ff <= 1'b0;
        end
        else
        begin
            comp_s1_ff <= comp_in;
            comp_s2_ff <= comp_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end
        else
        begin
            pready_ff <= acc;
            pslverr_ff <= acc && !hit_any;
            prdata_ff <= (acc && !pwrite) ? rd_data : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // registers software writes
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= '0;
            div_sel_ff <= adcseq_pkg::RST_DIV_SEL;
            mask_ff <= adcseq_pkg::RST_FLAG;
            status_ff <= adcseq_pkg::RST_FLAG;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            if (wr_ctrl1)
                div_sel_ff <= pwdata[adcseq_pkg::DIV_W-1:0];
            mask_ff <= nxt_mask;
            status_ff <= nxt_status; // set wins over clear
        end
    end

    // ------------------------------------------------------------
    // sequencer and successive approximation, no software help
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= adcseq_pkg::ST_IDLE;
            phase_cnt_ff <= 4'h0;
            code_ff <= '0;
            bit_ff <= '0;
            result_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (go || (nxt_state != state_ff))
                phase_cnt_ff <= 4'h0;
            else if (tick && running)
                phase_cnt_ff <= phase_cnt_ff + 4'h1;
            if (state_ff == adcseq_pkg::ST_SAMPLE && nxt_state == adcseq_pkg::ST_CONVERT)
            begin
                code_ff <= msb; // first trial is half scale
                bit_ff <= msb;
            end
            else if (state_ff == adcseq_pkg::ST_CONVERT && tick)
            begin
                code_ff <= sar_next; // one bit per period
                bit_ff <= bit_ff >> 1;
            end
            if (done_ev)
                result_ff <= sar_next;
        end
    end

    // ------------------------------------------------------------
    // outputs toward the analog macro and interrupt
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_on_ff <= 1'b0;
            sample_ff <= 1'b0;
            reset_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            power_on_ff <= new_power;
            sample_ff <= (nxt_state == adcseq_pkg::ST_SAMPLE);
            reset_ff <= new_start;
            irq_ff <= nxt_status && nxt_mask && new_gie;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign conv_power_on = power_on_ff;
    assign conv_sample = sample_ff;
    assign conv_reset = reset_ff;
    assign sar_code = code_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [4:0] ticks_h; // converter periods since start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ticks_h <= 5'h0;
        else if (go)
            ticks_h <= 5'h0;
        else if (running && tick)
            ticks_h <= ticks_h + 5'h1;
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_busy_set: assert property (go |=> ctrl_ff.busy && conv_sample)
        else $error("busy not set after start");
    a_busy_clear: assert property (done_ev |=> !ctrl_ff.busy && !conv_sample)
        else $error("busy not cleared at completion");
    a_done_flag: assert property (done_ev |=> status_ff ##1 status_ff || $past(wr_stat))
        else $error("completion flag not set");
    a_irq_level: assert property (irq == (status_ff && mask_ff && ctrl_ff.gie))
        else $error("interrupt level disagrees with flags");
    a_power_gate: assert property (!conv_power_on |-> !ctrl_ff.busy)
        else $error("busy while converter unpowered");
    a_sample_len: assert property ($fell(conv_sample) && ctrl_ff.busy |-> ticks_h == 5'h4)
        else $error("sampling phase not four periods");
    a_total_len: assert property ($fell(ctrl_ff.busy) && $past(done_ev)
        |-> ticks_h == adcseq_pkg::TOTAL_PERIODS)
        else $error("conversion not sixteen periods");
    a_result_hold: assert property (!$past(done_ev) |-> $stable(result_ff))
        else $error("result changed without completion");
    a_start_hold: assert property (nxt_ctrl.start |=> !running && conv_reset)
        else $error("converter not held while start high");
    a_apb_answer: assert property (acc |=> pready ##1 !pready)
        else $error("bus answer not one cycle");

endmodule // adcseq_top

/* File: tb/adcseq_bench.sv */
`timescale 1ns/10ps
module adcseq_bench;
    // ----------------------------------------------------------------
    // stimulus and observation signals
    // ----------------------------------------------------------------
    logic pclk = 1'b0; // 50 MHz system clock
    logic presetn = 1'b0; // active-low reset
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic conv_power_on;
    logic conv_sample;
    logic conv_reset;
    logic [11:0] sar_code;
    logic comp_in = 1'b0; // comparator answer of the modelled input
    logic [11:0] target = 12'h0; // analog level in code units
    int num_errors = 0;
    int samples_checked = 0;
    int cyc = 0; // free-running cycle count
    int run_len = 0; // current sampling run
    int samp_len = 0; // last finished sampling run
    int seed = 32'h7c075e79;
    logic [31:0] rdv; // scratch read value
    logic rerr; // scratch error flag

    adcseq_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .conv_power_on(conv_power_on), .conv_sample(conv_sample),
        .conv_reset(conv_reset), .sar_code(sar_code), .comp_in(comp_in)
    );

    // clock generator, 20 ns period
    initial
    begin
        forever #10 pclk = ~pclk;
    end

    // comparator model: input at or above trial code answers one
    always @(posedge pclk)
    begin
        comp_in <= (target >= sar_code);
        cyc <= cyc + 1;
        if (conv_sample === 1'b1)
            run_len <= run_len + 1;
        else if (run_len != 0)
        begin
            samp_len <= run_len;
            run_len <= 0;
        end
    end

    // ----------------------------------------------------------------
    // comparison and closing
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (num_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // apb master: setup, then access until pready
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            num_errors++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, rdv, rerr);
    endtask

    // read and compare one register
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rdv, rerr);
        check(what, rdv, exp);
    endtask

    // ----------------------------------------------------------------
    // one conversion at a given divider, flags checked, result checked on codes 5 and up
    // ----------------------------------------------------------------
    task automatic run_conv(input logic [2:0] sel, input logic [11:0] tgt, input logic ien);
        int per;
        int t0;
        int n;
        logic first_busy;
        per = 1 << sel;
        target = tgt;
        wr(adcseq_pkg::OFS_CTRL1, {29'h0, sel});
        wr(adcseq_pkg::OFS_MASK, {31'h0, ien});
        wr(adcseq_pkg::OFS_CTRL0, 32'h0000000b); // gie, power, start high
        repeat (2) @(posedge pclk);
        check("conv_reset", {31'h0, conv_reset}, 32'h1);
        check("power_on", {31'h0, conv_power_on}, 32'h1);
        wr(adcseq_pkg::OFS_CTRL0, 32'h0000000a); // falling start begins
        t0 = cyc;
        apb(1'b0, adcseq_pkg::OFS_CTRL0, 32'h0, rdv, rerr);
        first_busy = rdv[adcseq_pkg::CTRL0_BUSY];
        check("busy_set", {31'h0, first_busy}, 32'h1);
        n = 0;
        // poll busy until it drops, as software without interrupts would
        while (rdv[adcseq_pkg::CTRL0_BUSY] !== 1'b0 && n < 1000)
        begin
            apb(1'b0, adcseq_pkg::OFS_CTRL0, 32'h0, rdv, rerr);
            n++;
        end
        if (n >= 1000)
        begin
            num_errors++;
            stop_test();
        end
        t0 = cyc - t0;
        check("conv_time", {31'h0, (t0 >= 16 * per) && (t0 <= 16 * per + 8)}, 32'h1);
        check("sample_time", {31'h0, (samp_len >= 4 * per - 1) && (samp_len <= 4 * per + 2)},
              32'h1);
        rd_chk("status_done", adcseq_pkg::OFS_STATUS, 32'h1);
        // codes 0 to 4 go unchecked; codes 0 and 1 leave the comparator path too little settling time
        if (sel >= 3'h5)
        begin
            rd_chk("result_lo", adcseq_pkg::OFS_RES_LO, {24'h0, tgt[7:0]});
            rd_chk("result_hi", adcseq_pkg::OFS_RES_HI, {28'h0, tgt[11:8]});
        end
        check("irq_level", {31'h0, irq}, {31'h0, ien});
        wr(adcseq_pkg::OFS_STATUS, 32'h1); // write one to clear
        repeat (2) @(posedge pclk);
        check("irq_clear", {31'h0, irq}, 32'h0);
        rd_chk("status_clear", adcseq_pkg::OFS_STATUS, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [11:0] tv;
        repeat (10) @(posedge pclk);
        check("reset_outputs", {28'h0, irq, conv_power_on, conv_sample, conv_reset}, 32'h0);
        presetn <= 1'b1;
        rd_chk("ctrl0_reset", adcseq_pkg::OFS_CTRL0, 32'h0);
        rd_chk("ctrl1_reset", adcseq_pkg::OFS_CTRL1, 32'h0);
        rd_chk("status_reset", adcseq_pkg::OFS_STATUS, 32'h0);
        rd_chk("mask_reset", adcseq_pkg::OFS_MASK, 32'h0);
        // busy bit cannot be written by software
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000004);
        rd_chk("busy_ro", adcseq_pkg::OFS_CTRL0, 32'h0);
        // unmapped address is refused
        apb(1'b0, 8'h18, 32'h0, rdv, rerr);
        check("unmapped_err", {31'h0, rerr}, 32'h1);
        check("unmapped_data", rdv, 32'h0);
        // start pulse with power off: nothing happens
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000001);
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000000);
        rd_chk("no_power_idle", adcseq_pkg::OFS_CTRL0, 32'h0);
        // power up and settle before any start
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000002);
        repeat (20) @(posedge pclk);
        // every divider code, corner targets on checked codes, irq on alternate runs
        for (int i = 0; i < 8; i++)
        begin
            tv = 12'($random(seed));
            if (i == 5)
                tv = 12'h000;
            if (i == 6)
                tv = 12'hfff;
            run_conv(i[2:0], tv, i[0]);
        end
        // start high mid conversion aborts it without a flag
        wr(adcseq_pkg::OFS_CTRL1, 32'h2);
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000003);
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000002);
        repeat (10) @(posedge pclk);
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000003);
        rd_chk("restart_hold", adcseq_pkg::OFS_CTRL0, 32'h00000003);
        // power off mid conversion aborts it and drops the analog supply
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000002);
        repeat (10) @(posedge pclk);
        wr(adcseq_pkg::OFS_CTRL0, 32'h00000000);
        repeat (2) @(posedge pclk);
        check("power_off", {30'h0, conv_power_on, conv_sample}, 32'h0);
        rd_chk("abort_idle", adcseq_pkg::OFS_CTRL0, 32'h0);
        rd_chk("abort_noflag", adcseq_pkg::OFS_STATUS, 32'h0);
        stop_test();
    end

    // overall watchdog against a hang
    initial
    begin
        repeat (100000) @(posedge pclk);
        num_errors++;
        stop_test();
    end
endmodule // adcseq_bench
